// file: verilog/height_ctrl.sv
// Arc voltage torch height controller with APB registers
//
// Overview of operation
// - Inside setpoint plus or minus the dead band no raise or lower is requested.
// - Correction is held off while arc voltage is at or below the minimum arc threshold.
// - In test mode the up key raises, or steps with direction in normal sense.
// - In test mode the down key lowers, or steps with direction inverted.
// - The probe output is low while the nozzle touches the plate, high otherwise.
// - Step rate is programmable in hertz and resets to 400 Hz.
// - Direction polarity one gives normal direction, zero gives inverted direction.
// - With no key pressed for a while, parameter edit is left and control resumes.
// - Outside test mode, correction outputs stay off until an arc is detected.
// - After arc start a programmable settle delay passes before correction.
module height_ctrl
#(
	parameter int unsigned MENU_IDLE_CYC = height_ctrl_pkg::MENU_IDLE_CYC
)
(
	input  wire logic                          clk_i,
	input  wire logic                          rstn_i,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [7:0]                    paddr,
	input  wire logic [31:0]                   pwdata,
	output logic      [31:0]                   prdata,
	output logic                               pready,
	output logic                               pslverr,
	input  wire logic [height_ctrl_pkg::VOLT_W-1:0] arc_voltage_i,
	input  wire logic                          sample_valid_i,
	input  wire logic                          arc_detect_i,
	input  wire logic                          key_up_i,
	input  wire logic                          key_down_i,
	input  wire logic                          key_menu_i,
	input  wire logic                          nozzle_contact_i,
	output logic                               raise_request_o,
	output logic                               lower_request_o,
	output logic                               step_o,
	output logic                               dir_o,
	output logic                               probe_n_o
);

	localparam int unsigned VW = height_ctrl_pkg::VOLT_W;

	// Configuration registers
	logic [3:0]    ctrl;
	logic [VW-1:0] setpoint;
	logic [VW-1:0] dead_band_setting;
	logic [VW-1:0] minimum_arc_threshold;
	logic [31:0]   settle_cycles;
	logic [31:0]   correction_step_rate;

	// Run state
	height_ctrl_pkg::arc_state_e state;
	height_ctrl_pkg::arc_state_e next_state;
	logic [31:0]   settle_cnt;
	logic [31:0]   idle_cnt;
	logic [VW-1:0] volt;
	logic          raise_q;
	logic          lower_q;
	logic          probe_q;

	// APB decode
	wire           wr_en   = psel && penable && pwrite;
	wire           sel_ctl = (paddr == height_ctrl_pkg::OFS_CTRL);
	wire           sel_sp  = (paddr == height_ctrl_pkg::OFS_SETPOINT);
	wire           sel_db  = (paddr == height_ctrl_pkg::OFS_DEADBAND);
	wire           sel_ma  = (paddr == height_ctrl_pkg::OFS_MINARC);
	wire           sel_st  = (paddr == height_ctrl_pkg::OFS_SETTLE);
	wire           sel_sr  = (paddr == height_ctrl_pkg::OFS_STEPRATE);
	wire           sel_sts = (paddr == height_ctrl_pkg::OFS_STATUS);
	wire           sel_v   = (paddr == height_ctrl_pkg::OFS_VOLTAGE);
	wire           mapped  = sel_ctl | sel_sp | sel_db | sel_ma | sel_st | sel_sr
	                       | sel_sts | sel_v;
	wire           ro_hit  = sel_sts | sel_v;

	// Control fields
	wire           stepper_mode = ctrl[height_ctrl_pkg::CTRL_STEPPER];
	wire           dir_pol      = ctrl[height_ctrl_pkg::CTRL_DIRPOL];
	wire           test_mode    = ctrl[height_ctrl_pkg::CTRL_TEST];
	wire           edit_mode    = ctrl[height_ctrl_pkg::CTRL_EDIT];
	wire           any_key      = key_up_i | key_down_i | key_menu_i;
	wire           idle_expire  = edit_mode && !any_key
	                            && (idle_cnt >= (MENU_IDLE_CYC - 1));

	// Band limits, saturated
	wire [VW:0]    hi_sum  = {1'b0, setpoint} + {1'b0, dead_band_setting};
	wire [VW-1:0]  hi_lim  = hi_sum[VW] ? {VW{1'b1}} : hi_sum[VW-1:0];
	wire [VW-1:0]  lo_lim  = (dead_band_setting > setpoint) ? '0
	                        : setpoint - dead_band_setting;
	wire           above   = volt > hi_lim;
	wire           below   = volt < lo_lim;
	wire           arc_ok  = arc_detect_i && (volt > minimum_arc_threshold);
	wire           running = (state == height_ctrl_pkg::ST_ACTIVE) && !test_mode && !edit_mode;

	// Requested direction
	wire           auto_up   = running && below;
	wire           auto_down = running && above;
	wire           test_up   = test_mode && key_up_i && !key_down_i;
	wire           test_down = test_mode && key_down_i && !key_up_i;
	wire           want_up   = auto_up | test_up;
	wire           want_down = auto_down | test_down;

	// Read mux
	wire [31:0]    status_word = {27'h0, probe_q, lower_q, raise_q, state};
	wire [31:0]    rd_mux =
		sel_ctl ? {28'h0, ctrl} :
		sel_sp  ? {16'h0, setpoint} :
		sel_db  ? {16'h0, dead_band_setting} :
		sel_ma  ? {16'h0, minimum_arc_threshold} :
		sel_st  ? settle_cycles :
		sel_sr  ? correction_step_rate :
		sel_sts ? status_word :
		sel_v   ? {16'h0, volt} : 32'h0000_0000;

	assign pready  = 1'b1;
	assign pslverr = psel && penable && (!mapped || (pwrite && ro_hit));

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			prdata <= 32'h0000_0000;
		else if (psel && !penable && !pwrite)
			prdata <= rd_mux;
	end

	// Register writes and menu timeout
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			ctrl                  <= height_ctrl_pkg::CTRL_RESET;
			setpoint              <= height_ctrl_pkg::SETPOINT_RESET;
			dead_band_setting     <= height_ctrl_pkg::DEADBAND_RESET;
			minimum_arc_threshold <= height_ctrl_pkg::MINARC_RESET;
			settle_cycles         <= height_ctrl_pkg::SETTLE_RESET;
			correction_step_rate  <= height_ctrl_pkg::DEF_STEP_HZ;
		end
		else
		begin
			if (wr_en && sel_ctl)
				ctrl <= pwdata[3:0];
			else if (idle_expire)
				ctrl[height_ctrl_pkg::CTRL_EDIT] <= 1'b0;
			if (wr_en && sel_sp)
				setpoint <= pwdata[VW-1:0];
			if (wr_en && sel_db)
				dead_band_setting <= pwdata[VW-1:0];
			if (wr_en && sel_ma)
				minimum_arc_threshold <= pwdata[VW-1:0];
			if (wr_en && sel_st)
				settle_cycles <= pwdata;
			if (wr_en && sel_sr)
				correction_step_rate <= pwdata;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			idle_cnt <= 32'h0000_0000;
		else if (!edit_mode || any_key)
			idle_cnt <= 32'h0000_0000;
		else if (!idle_expire)
			idle_cnt <= idle_cnt + 32'h0000_0001;
	end

	// Voltage sample hold
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			volt <= '0;
		else if (sample_valid_i)
			volt <= arc_voltage_i;
	end

	// Arc state machine
	always_comb
	begin
		next_state = state;
		case (state)
			height_ctrl_pkg::ST_NO_ARC:
				if (arc_ok)
					next_state = height_ctrl_pkg::ST_SETTLE;
			height_ctrl_pkg::ST_SETTLE:
				if (!arc_ok)
					next_state = height_ctrl_pkg::ST_NO_ARC;
				else if (settle_cnt >= settle_cycles)
					next_state = height_ctrl_pkg::ST_ACTIVE;
			height_ctrl_pkg::ST_ACTIVE:
				if (!arc_ok)
					next_state = height_ctrl_pkg::ST_NO_ARC;
			default:
				next_state = height_ctrl_pkg::ST_NO_ARC;
		endcase
	end

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			state      <= height_ctrl_pkg::ST_NO_ARC;
			settle_cnt <= 32'h0000_0000;
		end
		else
		begin
			state <= next_state;
			if (state == height_ctrl_pkg::ST_SETTLE && next_state == state)
				settle_cnt <= settle_cnt + 32'h0000_0001;
			else
				settle_cnt <= 32'h0000_0000;
		end
	end

	// Output flops
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			raise_q <= 1'b0;
			lower_q <= 1'b0;
			probe_q <= 1'b0;
		end
		else
		begin
			raise_q <= want_up && !stepper_mode;
			lower_q <= want_down && !stepper_mode;
			probe_q <= !nozzle_contact_i;
		end
	end

	height_ctrl_pkg::step_out_s step_bus;

	step_pulser u_step
	(
		.clk_i     (clk_i),
		.rstn_i    (rstn_i),
		.run_i     (stepper_mode && (want_up ^ want_down)),
		.up_i      (want_up),
		.dir_pol_i (dir_pol),
		.rate_hz_i (correction_step_rate),
		.step_o    (step_bus)
	);

	assign raise_request_o = raise_q;
	assign lower_request_o = lower_q;
	assign step_o          = step_bus.step;
	assign dir_o           = step_bus.dir;
	assign probe_n_o       = probe_q;

endmodule : height_ctrl

// file: verilog/height_ctrl_pkg.sv
// Package: register map, field layout, reset values and timing for the height controller
package height_ctrl_pkg;

	localparam int unsigned CLK_HZ        = 100_000_000;
	localparam logic [31:0] DEF_STEP_HZ   = 32'd400;
	localparam int unsigned VOLT_W        = 16;

	// Idle time before leaving parameter edit, in ms
	localparam int unsigned MENU_IDLE_MS  = 10_000;
	localparam int unsigned MENU_IDLE_CYC = (CLK_HZ / 1000) * MENU_IDLE_MS;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL      = 8'h00;
	localparam logic [7:0] OFS_SETPOINT  = 8'h04;
	localparam logic [7:0] OFS_DEADBAND  = 8'h08;
	localparam logic [7:0] OFS_MINARC    = 8'h0C;
	localparam logic [7:0] OFS_SETTLE    = 8'h10;
	localparam logic [7:0] OFS_STEPRATE  = 8'h14;
	localparam logic [7:0] OFS_STATUS    = 8'h18;
	localparam logic [7:0] OFS_VOLTAGE   = 8'h1C;

	// Control register fields
	localparam int unsigned CTRL_STEPPER = 0;
	localparam int unsigned CTRL_DIRPOL  = 1;
	localparam int unsigned CTRL_TEST    = 2;
	localparam int unsigned CTRL_EDIT    = 3;
	localparam logic [3:0]  CTRL_RESET   = 4'h2;

	localparam logic [VOLT_W-1:0] SETPOINT_RESET = 16'h0078;
	localparam logic [VOLT_W-1:0] DEADBAND_RESET = 16'h0005;
	localparam logic [VOLT_W-1:0] MINARC_RESET   = 16'h0032;
	localparam logic [31:0]       SETTLE_RESET   = 32'h0001_86A0;

	typedef enum logic [1:0] {
		ST_NO_ARC = 2'b00,
		ST_SETTLE = 2'b01,
		ST_ACTIVE = 2'b10
	} arc_state_e;

	typedef struct packed {
		logic raise;
		logic lower;
	} move_req_s;

	typedef struct packed {
		logic step;
		logic dir;
	} step_out_s;

	function automatic logic [31:0] step_div(input logic [31:0] hz);
		logic [31:0] h;
		h = (hz == 32'h0000_0000) ? 32'h0000_0001 : hz;
		step_div = 32'(CLK_HZ) / h;
	endfunction : step_div

endpackage : height_ctrl_pkg

// file: verilog/step_pulser.sv
// Step pulse generator with programmable rate and direction polarity
module step_pulser
(
	input  wire logic                      clk_i,
	input  wire logic                      rstn_i,
	input  wire logic                      run_i,
	input  wire logic                      up_i,
	input  wire logic                      dir_pol_i,
	input  wire logic [31:0]               rate_hz_i,
	output height_ctrl_pkg::step_out_s     step_o
);

	logic [31:0] period;
	logic [31:0] cnt;
	logic        tick;
	logic        step_q;
	logic        dir_q;
	logic        next_dir;

	assign period   = height_ctrl_pkg::step_div(rate_hz_i);
	assign tick     = run_i && (cnt >= (period - 32'h0000_0001));
	assign next_dir = dir_pol_i ? up_i : !up_i;

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			cnt    <= 32'h0000_0000;
			step_q <= 1'b0;
			dir_q  <= 1'b0;
		end
		else
		begin
			dir_q <= next_dir;
			if (!run_i)
			begin
				cnt    <= 32'h0000_0000;
				step_q <= 1'b0;
			end
			else if (tick)
			begin
				cnt    <= 32'h0000_0000;
				step_q <= 1'b1;
			end
			else
			begin
				cnt    <= cnt + 32'h0000_0001;
				step_q <= (cnt < (period >> 1)) ? step_q : 1'b0;
			end
		end
	end

	assign step_o.step = step_q;
	assign step_o.dir  = dir_q;

endmodule : step_pulser

// file: tb/height_ctrl_props.sv
// Checker: port-level properties of the height controller
module height_ctrl_props
(
	input wire logic       clk_i,
	input wire logic       rstn_i,
	input wire logic       psel,
	input wire logic       penable,
	input wire logic [7:0] paddr,
	input wire logic       pready,
	input wire logic       pslverr,
	input wire logic       arc_detect_i,
	input wire logic       key_up_i,
	input wire logic       key_down_i,
	input wire logic       nozzle_contact_i,
	input wire logic       raise_request_o,
	input wire logic       lower_request_o,
	input wire logic       step_o,
	input wire logic       probe_n_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);

	a_probe_touch: assert property (rstn_i && nozzle_contact_i |=> !probe_n_o)
		else $error("probe high in contact");
	a_probe_free: assert property (rstn_i && !nozzle_contact_i |=> probe_n_o)
		else $error("probe low without contact");
	a_no_arc_quiet: assert property ((!arc_detect_i && !key_up_i && !key_down_i) [*4]
		|-> !raise_request_o && !lower_request_o) else $error("request without arc");
	a_one_way: assert property (!(raise_request_o && lower_request_o))
		else $error("raise and lower together");
	a_raise_cause: assert property ($rose(raise_request_o) |-> $past(arc_detect_i)
		|| $past(arc_detect_i, 2) || $past(key_up_i) || $past(key_up_i, 2))
		else $error("raise without cause");
	a_lower_cause: assert property ($rose(lower_request_o) |-> $past(arc_detect_i)
		|| $past(arc_detect_i, 2) || $past(key_down_i) || $past(key_down_i, 2))
		else $error("lower without cause");
	a_step_cause: assert property ($rose(step_o) |-> $past(arc_detect_i || key_up_i
		|| key_down_i) || $past(arc_detect_i || key_up_i || key_down_i, 2))
		else $error("step without cause");
	a_bad_addr: assert property (psel && penable && paddr > 8'h1C |-> pslverr)
		else $error("unmapped access accepted");
	a_zero_wait: assert property (psel && penable |-> pready) else $error("access stalled");
endmodule : height_ctrl_props

bind height_ctrl height_ctrl_props height_ctrl_props_i (.clk_i, .rstn_i, .psel, .penable,
	.paddr, .pready, .pslverr, .arc_detect_i, .key_up_i, .key_down_i, .nozzle_contact_i,
	.raise_request_o, .lower_request_o, .step_o, .probe_n_o);

// file: tb/step_drv_model.sv
// Stepper driver model: counts step pulses, keeps direction at each step
module step_drv_model
(
	input  wire logic clk_i,
	input  wire logic step_i,
	input  wire logic dir_i,
	output int        steps_o,
	output logic      dir_seen_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic prev = 1'h0;
	initial steps_o = 0;
	always @(posedge clk_i)
	begin
		prev <= step_i;
		if (step_i && !prev)
		begin
			steps_o <= steps_o + 1;
			dir_seen_o <= dir_i;
		end
	end
endmodule : step_drv_model

// file: tb/tb_top.sv
// Testbench: APB and pin scenarios for the height controller
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_i, rstn_i, psel, penable, pwrite, pready, pslverr, e, dseen;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [15:0] arc_voltage_i;
	logic        sample_valid_i, arc_detect_i, key_up_i, key_down_i, key_menu_i;
	logic        nozzle_contact_i, raise_request_o, lower_request_o, step_o, dir_o, probe_n_o;
	int          steps, s0, errors, tests_run;

	height_ctrl #(.MENU_IDLE_CYC(50)) height_ctrl_i (.clk_i, .rstn_i, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .arc_voltage_i, .sample_valid_i,
		.arc_detect_i, .key_up_i, .key_down_i, .key_menu_i, .nozzle_contact_i,
		.raise_request_o, .lower_request_o, .step_o, .dir_o, .probe_n_o);
	step_drv_model step_drv_model_i (.clk_i, .step_i(step_o), .dir_i(dir_o), .steps_o(steps),
		.dir_seen_o(dseen));

	initial
	begin
		clk_i = 1'h0;
		forever #5 clk_i = ~clk_i;
	end

	task go(input int n);
		repeat (n) @(posedge clk_i);
	endtask : go

	task check(input string n, input logic [31:0] s, input logic [31:0] x);
		tests_run++;
		if (s !== x)
		begin
			errors++;
			$display("BAD %s expected %h seen %h", n, x, s);
		end
	endtask : check

	task wrap_up;
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : wrap_up

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1'h1;
		do
			@(posedge clk_i);
		while (pready !== 1'h1);
		rdat = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb

	task rd(input string n, input logic [7:0] a, input logic [31:0] x);
		apb(1'h0, a, 32'h0);
		check(n, rdat, x);
	endtask : rd

	task volt(input logic [15:0] v);
		arc_voltage_i <= v;
		sample_valid_i <= 1'h1;
		go(1);
		sample_valid_i <= 1'h0;
	endtask : volt

	initial
	begin
		{psel, penable, pwrite, sample_valid_i, arc_detect_i, key_up_i, key_down_i} = 7'h00;
		{key_menu_i, nozzle_contact_i, rstn_i} = 3'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		arc_voltage_i = 16'h0;
		errors = 0;
		tests_run = 0;
		go(16);
		rstn_i <= 1'h1;
		rd("ctrl", height_ctrl_pkg::OFS_CTRL, 32'h2);
		rd("rate", height_ctrl_pkg::OFS_STEPRATE, 32'h190);
		apb(1'h0, 8'h20, 32'h0);
		check("unmapped", e, 32'h1);
		apb(1'h1, height_ctrl_pkg::OFS_SETTLE, 32'h14);
		nozzle_contact_i <= 1'h1;
		go(3);
		check("probe touch", probe_n_o, 32'h0);
		nozzle_contact_i <= 1'h0;
		go(3);
		check("probe free", probe_n_o, 32'h1);
		volt(16'h0080);
		go(10);
		check("no arc", lower_request_o, 32'h0);
		arc_detect_i <= 1'h1;
		go(8);
		check("settling", lower_request_o, 32'h0);
		go(30);
		check("above band", lower_request_o, 32'h1);
		rd("status", height_ctrl_pkg::OFS_STATUS, 32'h1A);
		apb(1'h1, height_ctrl_pkg::OFS_VOLTAGE, 32'h0);
		check("ro write", e, 32'h1);
		rd("voltage", height_ctrl_pkg::OFS_VOLTAGE, 32'h80);
		apb(1'h1, height_ctrl_pkg::OFS_CTRL, 32'hA);
		go(3);
		check("edit hold", lower_request_o, 32'h0);
		go(60);
		check("edit resume", lower_request_o, 32'h1);
		volt(16'h007D);
		go(3);
		check("band top", {raise_request_o, lower_request_o}, 32'h0);
		volt(16'h0073);
		go(3);
		check("band low", {raise_request_o, lower_request_o}, 32'h0);
		volt(16'h0072);
		go(3);
		check("below band", raise_request_o, 32'h1);
		volt(16'h0032);
		go(5);
		check("min arc", {raise_request_o, lower_request_o}, 32'h0);
		arc_detect_i <= 1'h0;
		apb(1'h1, height_ctrl_pkg::OFS_CTRL, 32'h6);
		key_up_i <= 1'h1;
		go(3);
		check("test up", {raise_request_o, lower_request_o}, 32'h2);
		key_up_i <= 1'h0;
		key_down_i <= 1'h1;
		go(3);
		check("test down", {raise_request_o, lower_request_o}, 32'h1);
		key_down_i <= 1'h0;
		apb(1'h1, height_ctrl_pkg::OFS_STEPRATE, 32'h000F4240);
		for (int k = 0; k < 4; k++)
		begin
			apb(1'h1, height_ctrl_pkg::OFS_CTRL, {29'h0, 1'h1, k[1], 1'h1});
			key_up_i <= k[0];
			key_down_i <= !k[0];
			s0 = steps;
			go(1050);
			check("steps", (steps - s0) inside {[9:11]}, 32'h1);
			check("dir", dseen, 32'(k[0] == k[1]));
			key_up_i <= 1'h0;
			key_down_i <= 1'h0;
		end
		apb(1'h1, height_ctrl_pkg::OFS_CTRL, 32'hA);
		go(40);
		key_menu_i <= 1'h1;
		go(1);
		key_menu_i <= 1'h0;
		go(30);
		rd("edit held", height_ctrl_pkg::OFS_CTRL, 32'hA);
		go(40);
		rd("edit left", height_ctrl_pkg::OFS_CTRL, 32'h2);
		wrap_up;
	end

	initial
	begin
		go(20000);
		errors++;
		wrap_up;
	end
endmodule : tb_top
